// ### common/key_bank_pkg.sv
// Constants, register map and bus carrier for the key input bank
package key_bank_pkg;
   localparam int unsigned KEY_WORDS = 8;
   localparam int unsigned WORD_W    = 32;
   localparam int unsigned KEY_W     = KEY_WORDS * WORD_W;
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned IDX_W     = 3;
   localparam int unsigned IDX_LSB   = 2;
   localparam int unsigned REGION_LSB = 5;

   // Byte addresses of the register groups
   localparam logic [11:0] DBG_KEY_BASE  = 12'h040;
   localparam logic [11:0] TST_KEY_BASE  = 12'h060;
   localparam logic [11:0] LOCK_STAT_ADR = 12'h080;

   // Lock status register fields (1 = protection released)
   localparam int unsigned STAT_DBG_OPEN = 0;
   localparam int unsigned STAT_TST_OPEN = 1;

   // Reset value of every key word
   localparam logic [31:0] KEY_RESET = 32'h0000_0000;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Bus codes
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

   // Captured address phase
   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic        word;
   } ahb_req_s;
endpackage

// ### rtl/id_auth_key_input_bank.sv
// Authentication key input bank with AHB-Lite register access
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps

module id_auth_key_input_bank #(
   parameter int unsigned ADDR_W = key_bank_pkg::ADDR_W
) (
   input  wire logic                    clk,                // System clock
   input  wire logic                    rst_b,              // Async reset, active low
   input  wire logic                    hsel,               // Slave select
   input  wire logic [ADDR_W-1:0]       haddr,              // Byte address
   input  wire logic [1:0]              htrans,             // Transfer type
   input  wire logic                    hwrite,             // Write when high
   input  wire logic [2:0]              hsize,              // Transfer size
   input  wire logic [31:0]             hwdata,             // Write data
   input  wire logic                    hready,             // Bus ready
   output logic                         hreadyout,          // Slave ready
   output logic                         hresp,              // Always OKAY
   output logic [31:0]                  hrdata,             // Read data
   input  wire logic [255:0]            ref_debug_key,      // Stored debug reference
   input  wire logic [255:0]            ref_test_key,       // Stored test reference
   output logic                         debug_setting_lock, // High while debug locked
   output logic                         test_entry_lock     // High while test entry locked
);

   localparam int unsigned NW = key_bank_pkg::KEY_WORDS;
   localparam int unsigned WW = key_bank_pkg::WORD_W;
   localparam int unsigned IL = key_bank_pkg::IDX_LSB;
   localparam int unsigned RL = key_bank_pkg::REGION_LSB;

   // Map must fit the address bus
   if (ADDR_W < key_bank_pkg::ADDR_W) begin : g_bad_addr
      $error("ADDR_W too small for the register map");
   end

   logic [WW-1:0]            dbg_q [NW];
   logic [WW-1:0]            tst_q [NW];
   logic [key_bank_pkg::KEY_W-1:0] dbg_key_w;
   logic [key_bank_pkg::KEY_W-1:0] tst_key_w;
   key_bank_pkg::ahb_req_s   req_d;
   key_bank_pkg::ahb_req_s   req_q;
   logic                     wr_pend_q;
   logic                     dbg_open_q;
   logic                     tst_open_q;
   logic [31:0]              hrdata_q;
   logic [31:0]              rdata_d;

   // Key assembly, word n feeds bits n*32 upward
   for (genvar n = 0; n < NW; n++) begin : g_key
      assign dbg_key_w[n*WW +: WW] = dbg_q[n];
      assign tst_key_w[n*WW +: WW] = tst_q[n];
   end

   // Address phase decode
   wire        acc_w    = hsel && hready && htrans[key_bank_pkg::HTRANS_ACTIVE_BIT];
   wire [11:0] a_w      = haddr[11:0];
   wire [2:0]  a_idx_w  = a_w[IL +: key_bank_pkg::IDX_W];
   wire        a_dbg_w  = a_w[11:RL] == key_bank_pkg::DBG_KEY_BASE[11:RL];
   wire        a_tst_w  = a_w[11:RL] == key_bank_pkg::TST_KEY_BASE[11:RL];
   wire        a_stat_w = a_w[11:IL] == key_bank_pkg::LOCK_STAT_ADR[11:IL];
   wire        rd_acc_w = acc_w && !hwrite;

   // Data phase decode of the held write
   wire [2:0]  w_idx_w  = req_q.addr[IL +: key_bank_pkg::IDX_W];
   wire        w_ok_w   = wr_pend_q && req_q.word;
   wire        w_dbg_w  = w_ok_w && req_q.addr[11:RL] == key_bank_pkg::DBG_KEY_BASE[11:RL];
   wire        w_tst_w  = w_ok_w && req_q.addr[11:RL] == key_bank_pkg::TST_KEY_BASE[11:RL];
   // Forward only writes that really land, never to status or unmapped places
   wire        fwd_w    = (w_dbg_w || w_tst_w) && req_q.addr[11:IL] == a_w[11:IL];

   assign req_d.addr  = a_w;
   assign req_d.write = hwrite;
   assign req_d.word  = hsize == key_bank_pkg::HSIZE_WORD;

   // Read mux; a read right behind a write to the same word sees the new data
   always_comb begin
      rdata_d = key_bank_pkg::RDATA_ZERO;
      if (fwd_w) begin
         rdata_d = hwdata;
      end else if (a_dbg_w) begin
         rdata_d = dbg_q[a_idx_w];
      end else if (a_tst_w) begin
         rdata_d = tst_q[a_idx_w];
      end else if (a_stat_w) begin
         rdata_d[key_bank_pkg::STAT_DBG_OPEN] = dbg_open_q;
         rdata_d[key_bank_pkg::STAT_TST_OPEN] = tst_open_q;
      end
   end

   // Address phase capture and read data register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_q     <= '0;
         wr_pend_q <= 1'b0;
         hrdata_q  <= key_bank_pkg::RDATA_ZERO;
      end else begin
         wr_pend_q <= acc_w && hwrite;
         if (acc_w) begin
            req_q <= req_d;
         end
         if (rd_acc_w) begin
            hrdata_q <= rdata_d;
         end
      end
   end

   // Key word storage; only whole-word writes land, narrower ones are dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NW; i++) begin
            dbg_q[i] <= key_bank_pkg::KEY_RESET;
            tst_q[i] <= key_bank_pkg::KEY_RESET;
         end
      end else begin
         if (w_dbg_w) begin
            dbg_q[w_idx_w] <= hwdata;
         end
         if (w_tst_w) begin
            tst_q[w_idx_w] <= hwdata;
         end
      end
   end

   // Full-width comparison against the stored references, which are read only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dbg_open_q <= 1'b0;
         tst_open_q <= 1'b0;
      end else begin
         dbg_open_q <= dbg_key_w == ref_debug_key;
         tst_open_q <= tst_key_w == ref_test_key;
      end
   end

   // Outputs
   assign debug_setting_lock = !dbg_open_q;
   assign test_entry_lock    = !tst_open_q;
   assign hreadyout          = 1'b1;
   assign hresp              = key_bank_pkg::HRESP_OKAY;
   assign hrdata             = hrdata_q;

   // Checks on the lock decisions and the register file
   property p_dbg_match;
      @(posedge clk) disable iff (!rst_b)
      dbg_key_w == ref_debug_key |=> !debug_setting_lock;
   endproperty
   a_dbg_match: assert property (p_dbg_match)
      else $error("debug lock held despite matching key");

   property p_dbg_mismatch;
      @(posedge clk) disable iff (!rst_b)
      dbg_key_w != ref_debug_key |=> debug_setting_lock;
   endproperty
   a_dbg_mismatch: assert property (p_dbg_mismatch)
      else $error("debug lock released on mismatch");

   property p_tst_match;
      @(posedge clk) disable iff (!rst_b)
      tst_key_w == ref_test_key |=> !test_entry_lock;
   endproperty
   a_tst_match: assert property (p_tst_match)
      else $error("test entry lock held despite matching key");

   property p_tst_mismatch;
      @(posedge clk) disable iff (!rst_b)
      tst_key_w != ref_test_key |=> test_entry_lock;
   endproperty
   a_tst_mismatch: assert property (p_tst_mismatch)
      else $error("test entry lock released on mismatch");

   property p_dbg_place;
      @(posedge clk) disable iff (!rst_b)
      w_dbg_w |=> dbg_key_w[$past(w_idx_w)*WW +: WW] == $past(hwdata);
   endproperty
   a_dbg_place: assert property (p_dbg_place)
      else $error("debug word landed in wrong key bits");

   property p_tst_place;
      @(posedge clk) disable iff (!rst_b)
      w_tst_w |=> tst_key_w[$past(w_idx_w)*WW +: WW] == $past(hwdata);
   endproperty
   a_tst_place: assert property (p_tst_place)
      else $error("test word landed in wrong key bits");

   property p_narrow_ignored;
      @(posedge clk) disable iff (!rst_b)
      wr_pend_q && !req_q.word |=> $stable(dbg_key_w) && $stable(tst_key_w);
   endproperty
   a_narrow_ignored: assert property (p_narrow_ignored)
      else $error("narrow write changed a key word");

   property p_dbg_readback;
      @(posedge clk) disable iff (!rst_b)
      rd_acc_w && a_dbg_w && !fwd_w && !w_dbg_w |=> hrdata == $past(dbg_q[a_idx_w]);
   endproperty
   a_dbg_readback: assert property (p_dbg_readback)
      else $error("debug word read back wrong");

   c_dbg_unlock: cover property (@(posedge clk) disable iff (!rst_b)
      debug_setting_lock ##1 !debug_setting_lock);
   c_tst_unlock: cover property (@(posedge clk) disable iff (!rst_b)
      test_entry_lock ##1 !test_entry_lock);
   c_fwd_read: cover property (@(posedge clk) disable iff (!rst_b)
      rd_acc_w && fwd_w);
   c_narrow_write: cover property (@(posedge clk) disable iff (!rst_b)
      wr_pend_q && !req_q.word);
   c_stat_read: cover property (@(posedge clk) disable iff (!rst_b)
      rd_acc_w && a_stat_w);

   // Test-entry words read back what was stored
   property p_tst_readback;
      @(posedge clk) disable iff (!rst_b)
      rd_acc_w && a_tst_w && !fwd_w && !w_tst_w |=> hrdata == $past(tst_q[a_idx_w]);
   endproperty
   a_tst_readback: assert property (p_tst_readback)
      else $error("test entry word read back wrong");

   // Status register shows both release flags in the low bits
   property p_stat_read;
      @(posedge clk) disable iff (!rst_b)
      rd_acc_w && a_stat_w |=>
         hrdata == {30'h0000_0000, $past(tst_open_q), $past(dbg_open_q)};
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status read wrong");

   // Unmapped reads return zero
   property p_unmapped_read;
      @(posedge clk) disable iff (!rst_b)
      rd_acc_w && !a_dbg_w && !a_tst_w && !a_stat_w |=> hrdata == key_bank_pkg::RDATA_ZERO;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");

   // Read data holds until the next accepted read
   property p_hrdata_hold;
      @(posedge clk) disable iff (!rst_b)
      !rd_acc_w |=> $stable(hrdata);
   endproperty
   a_hrdata_hold: assert property (p_hrdata_hold)
      else $error("read data changed without a read");

   // Forwarded read returns the data of the write just before it
   property p_fwd_data;
      @(posedge clk) disable iff (!rst_b)
      rd_acc_w && fwd_w |=> hrdata == $past(hwdata);
   endproperty
   a_fwd_data: assert property (p_fwd_data)
      else $error("forwarded read data wrong");

   // Debug key changes only through a landing debug write
   property p_dbg_hold;
      @(posedge clk) disable iff (!rst_b)
      !w_dbg_w |=> $stable(dbg_key_w);
   endproperty
   a_dbg_hold: assert property (p_dbg_hold)
      else $error("debug key changed without a write");

   // Test-entry key changes only through a landing test write
   property p_tst_hold;
      @(posedge clk) disable iff (!rst_b)
      !w_tst_w |=> $stable(tst_key_w);
   endproperty
   a_tst_hold: assert property (p_tst_hold)
      else $error("test entry key changed without a write");

   // A debug write leaves the test-entry key alone
   property p_dbg_isolated;
      @(posedge clk) disable iff (!rst_b)
      w_dbg_w |=> $stable(tst_key_w);
   endproperty
   a_dbg_isolated: assert property (p_dbg_isolated)
      else $error("debug write touched test entry key");

   // A test-entry write leaves the debug key alone
   property p_tst_isolated;
      @(posedge clk) disable iff (!rst_b)
      w_tst_w |=> $stable(dbg_key_w);
   endproperty
   a_tst_isolated: assert property (p_tst_isolated)
      else $error("test entry write touched debug key");

   // Writes to the status register change no key
   property p_stat_readonly;
      @(posedge clk) disable iff (!rst_b)
      wr_pend_q && req_q.addr[11:IL] == key_bank_pkg::LOCK_STAT_ADR[11:IL] |=>
         $stable(dbg_key_w) && $stable(tst_key_w);
   endproperty
   a_stat_readonly: assert property (p_stat_readonly)
      else $error("status write changed a key");

   // Every accepted write opens a data phase
   property p_wr_pend;
      @(posedge clk) disable iff (!rst_b)
      acc_w && hwrite |=> wr_pend_q;
   endproperty
   a_wr_pend: assert property (p_wr_pend)
      else $error("write data phase missed");

   // No data phase without an accepted write
   property p_no_stray_write;
      @(posedge clk) disable iff (!rst_b)
      !(acc_w && hwrite) |=> !wr_pend_q;
   endproperty
   a_no_stray_write: assert property (p_no_stray_write)
      else $error("stray write data phase");

   // Slave never stalls and always answers OKAY
   property p_bus_okay;
      @(posedge clk) disable iff (!rst_b)
      hreadyout && hresp == key_bank_pkg::HRESP_OKAY;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus answer not ready or not okay");

   // Debug release only follows a full match one cycle earlier
   property p_dbg_release_cause;
      @(posedge clk) disable iff (!rst_b)
      $fell(debug_setting_lock) |-> $past(dbg_key_w == ref_debug_key);
   endproperty
   a_dbg_release_cause: assert property (p_dbg_release_cause)
      else $error("debug released without full match");

   // Test-entry release only follows a full match one cycle earlier
   property p_tst_release_cause;
      @(posedge clk) disable iff (!rst_b)
      $fell(test_entry_lock) |-> $past(tst_key_w == ref_test_key);
   endproperty
   a_tst_release_cause: assert property (p_tst_release_cause)
      else $error("test entry released without full match");

   // Key words are only written whole
   property p_word_only;
      @(posedge clk) disable iff (!rst_b)
      w_dbg_w || w_tst_w |-> req_q.word;
   endproperty
   a_word_only: assert property (p_word_only)
      else $error("narrow write reached a key word");
endmodule

// ### verif/test_id_auth_key_input_bank.sv
// Self-checking bench for the key input bank over AHB-Lite
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_id_auth_key_input_bank;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         hsel = 1'b0;
   logic         hwrite = 1'b0;
   logic [11:0]  haddr = 12'h000;
   logic [1:0]   htrans = 2'h0;
   logic [2:0]   hsize = 3'h2;
   logic [31:0]  hwdata = 32'h0000_0000;
   logic [31:0]  rd;
   logic         hreadyout;
   logic         hresp;
   logic [31:0]  hrdata;
   logic [255:0] ref_dbg;
   logic [255:0] ref_tst;
   logic         dbg_lock;
   logic         tst_lock;
   int           n_fail = 0;
   int           n_checks = 0;

   id_auth_key_input_bank dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_debug_key(ref_dbg),
      .ref_test_key(ref_tst), .debug_setting_lock(dbg_lock), .test_entry_lock(tst_lock));

   // 100 MHz clock
   always #5 clk = ~clk;

   // One single AHB transfer; waits on hready in both phases
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask

   // Read a word and compare
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 3'h2);
      `CHK(rd, e)
   endtask

   // Load eight words ascending; rev puts them in mirrored slots
   task automatic load(input logic [11:0] base, input logic [255:0] k, input bit rev);
      for (int n = 0; n < 8; n++) begin
         bus(1'b1, base + 12'(4 * n), k[32 * (rev ? 7 - n : n) +: 32], 3'h2);
      end
      @(posedge clk);
      #1;
   endtask

   // Reset contents and lock state
   task automatic t_reset;
      for (int n = 0; n < 8; n++) begin
         rchk(key_bank_pkg::DBG_KEY_BASE + 12'(4 * n), 32'h0000_0000);
         rchk(key_bank_pkg::TST_KEY_BASE + 12'(4 * n), 32'h0000_0000);
      end
      `CHK({dbg_lock, tst_lock}, 2'b11)
      rchk(key_bank_pkg::LOCK_STAT_ADR, 32'h0000_0000);
   endtask

   // Debug key: word placement, full match, single-bit mismatch, size refusal
   task automatic t_debug;
      load(key_bank_pkg::DBG_KEY_BASE, ref_dbg, 1'b1);
      `CHK(dbg_lock, 1'b1)
      load(key_bank_pkg::DBG_KEY_BASE, ref_dbg, 1'b0);
      `CHK(dbg_lock, 1'b0)
      `CHK(tst_lock, 1'b1)
      for (int n = 0; n < 8; n++) begin
         rchk(key_bank_pkg::DBG_KEY_BASE + 12'(4 * n), ref_dbg[32 * n +: 32]);
      end
      rchk(key_bank_pkg::LOCK_STAT_ADR, 32'h0000_0001);
      bus(1'b1, 12'h04C, ref_dbg[127:96] ^ 32'h0000_0100, 3'h2);
      @(posedge clk);
      #1;
      `CHK(dbg_lock, 1'b1)
      bus(1'b1, 12'h04C, ref_dbg[127:96], 3'h2);
      bus(1'b1, 12'h040, 32'hFFFF_FFFF, 3'h1);
      rchk(12'h040, ref_dbg[31:0]);
      `CHK(dbg_lock, 1'b0)
   endtask

   // Test-entry key, read-only status, unmapped place, reference change
   task automatic t_test;
      load(key_bank_pkg::TST_KEY_BASE, ref_tst, 1'b0);
      `CHK(tst_lock, 1'b0)
      bus(1'b1, key_bank_pkg::LOCK_STAT_ADR, 32'h0000_0000, 3'h2);
      rchk(key_bank_pkg::LOCK_STAT_ADR, 32'h0000_0003);
      rchk(12'h0FC, 32'h0000_0000);
      rchk(key_bank_pkg::TST_KEY_BASE + 12'h01C, ref_tst[255:224]);
      @(posedge clk);
      ref_tst[0] <= ~ref_tst[0];
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK(tst_lock, 1'b1)
      `CHK(dbg_lock, 1'b0)
   endtask

   // Verdict and end of run
   task automatic print_verdict;
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      for (int n = 0; n < 8; n++) begin
         ref_dbg[32 * n +: 32] = 32'hDB00_0000 + 32'(n) * 32'h0001_0101;
         ref_tst[32 * n +: 32] = 32'h7E00_0000 + 32'(n) * 32'h0101_0001;
      end
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_debug();
      t_test();
      print_verdict();
   end

   // Watchdog against a hung bus
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
endmodule
